/* File: common/ccs_pkg.sv */
package ccs_pkg;

    // Core clock rate and derived cycle counts.
    localparam int CLK_MHZ       = 50;
    localparam int STEP_NS       = 1000;
    localparam int STEP_CYC      = (STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int DEACT_GAP_NS  = 12000;
    localparam int DEACT_GAP_CYC = (DEACT_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int DEBOUNCE_US   = 8000;
    localparam int DEBOUNCE_CYC  = DEBOUNCE_US * CLK_MHZ;
    localparam int CNT_W         = 16;
    localparam int DIV_W         = 3;

    // Register map, byte addresses.
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic       CTRL_RST    = 1'h0;
    localparam int         CTRL_ABORT  = 0;
    localparam int         ST_PRESENT  = 0;
    localparam int         ST_INT      = 1;
    localparam int         ST_FAULT    = 2;
    localparam int         ST_SESSION  = 3;
    localparam int         ST_CLK      = 4;
    localparam int         ST_FSNAP    = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Card clock divider select codes {hi, lo}.
    localparam logic [1:0] DIV8 = 2'h0;
    localparam logic [1:0] DIV4 = 2'h1;
    localparam logic [1:0] DIV1 = 2'h2;
    localparam logic [1:0] DIV2 = 2'h3;

    // Positions inside the synchroniser vector.
    localparam int SY_REQ    = 0;
    localparam int SY_HRST   = 1;
    localparam int SY_DET    = 2;
    localparam int SY_DHI    = 3;
    localparam int SY_DLO    = 4;
    localparam int SY_STABLE = 5;
    localparam int SY_FLT    = 6;
    localparam int SY_CARD   = 11;
    localparam int SY_HOST   = 14;
    localparam int SY_W      = 17;

    typedef struct packed {
        logic supply_drop;
        logic vcc_fault;
        logic pump_in_low;
        logic pump_overload;
        logic overheat;
    } ccs_fault_t;

    typedef enum logic [3:0] {
        S_STANDBY, S_RAMP, S_ACT_IO, S_ACT_CLK, S_ACTIVE, S_DEACT_RST, S_DEACT_IO, S_DEACT_VCC
    } ccs_state_t;

    typedef enum logic [1:0] {C_IDLE, C_HOST, C_CARD} ccs_dir_t;

endpackage

/* File: logic/ccs_chan.sv */
`timescale 1ns/1ps
module ccs_chan
    import ccs_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_en,
    input  wire logic i_host_lvl,
    input  wire logic i_card_lvl,
    output logic      o_host_oe,
    output logic      o_card_oe
);

    ccs_dir_t dir_q;
    logic     armed_q;
    logic     host_oe_q;
    logic     card_oe_q;

    // A channel arms only once both sides read high after enable. Without this, the card contact
    // that standby held low would look like a card falling edge and drive the host pin.
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_en) begin
            armed_q <= 1'b0;
        end else if (i_host_lvl && i_card_lvl) begin
            armed_q <= 1'b1;
        end
    end

    // The first side seen low owns the channel until both sides read high again.
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_en) begin
            dir_q <= C_IDLE;
        end else begin
            case (dir_q)
                C_IDLE: begin
                    if (armed_q && !i_host_lvl) begin
                        dir_q <= C_HOST;
                    end else if (armed_q && !i_card_lvl) begin
                        dir_q <= C_CARD;
                    end
                end
                C_HOST, C_CARD: begin
                    if (i_host_lvl && i_card_lvl) begin
                        dir_q <= C_IDLE;
                    end
                end
                default: dir_q <= C_IDLE;
            endcase
        end
    end

    // Disabled channels hold the card contact low and release the host pin.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            card_oe_q <= 1'b1;
            host_oe_q <= 1'b0;
        end else begin
            card_oe_q <= !i_en || (dir_q == C_HOST && !i_host_lvl);
            host_oe_q <= i_en && dir_q == C_CARD && !i_card_lvl;
        end
    end

    assign o_card_oe = card_oe_q;
    assign o_host_oe = host_oe_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    AST_CHAN_NO_FIGHT: assert property (
        !(o_host_oe && o_card_oe && i_en && $past(i_en))) else $error("Both channel sides driven at once.");
    AST_CHAN_FOLLOW: assert property (
        (i_en && dir_q == C_HOST && !i_host_lvl) |=> o_card_oe) else $error("Card side did not follow host.");

endmodule

/* File: logic/ccs_sequencer.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ccs_sequencer
    import ccs_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    input  wire logic              i_session_request_n,
    input  wire logic              i_host_reset_request,
    input  wire logic              i_card_detect,
    input  wire logic              i_divider_select_hi,
    input  wire logic              i_divider_select_lo,
    input  wire logic              i_card_supply_stable,
    input  wire ccs_fault_t        i_fault,
    input  wire logic [2:0]        i_card_line,
    output logic [2:0]             o_card_line_o,
    output logic [2:0]             o_card_line_oe,
    input  wire logic [2:0]        i_host_line,
    output logic [2:0]             o_host_line_o,
    output logic [2:0]             o_host_line_oe,
    output logic                   o_card_supply_en,
    output logic                   o_card_reset_out,
    output logic                   o_card_clock_out,
    output logic                   o_int_n
);

    localparam int               DEB_W   = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [CNT_W-1:0] STEP_LD = CNT_W'(STEP_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LD  = CNT_W'(DEACT_GAP_CYC - 1);
    localparam logic [SY_W-1:0]  SY_IDLE = (SY_W'(1) << SY_REQ) | (SY_W'(7) << SY_CARD) | (SY_W'(7) << SY_HOST);

    logic [SY_W-1:0]  sync1_q;
    logic [SY_W-1:0]  sync2_q;
    ccs_state_t       state_q;
    logic [CNT_W-1:0] tmr_q;
    logic [CNT_W-1:0] gap_q;
    logic [DEB_W-1:0] deb_cnt_q;
    logic             present_q;
    logic             req_prev_q;
    logic             gated_q;
    logic             fault_q;
    logic [4:0]       fault_snap_q;
    logic             int_q;
    logic             supply_en_q;
    logic             rst_q;
    logic             clk_run_q;
    logic             io_en_q;
    logic [DIV_W-1:0] div_cnt_q;
    logic             card_clk_q;
    logic             ctrl_abort_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic             rvalid_q;
    logic [1:0]       rresp_q;
    logic [31:0]      rdata_q;
    logic [31:0]      status_w;
    ccs_fault_t       flt;
    logic             req_n;
    logic             host_rst;
    logic             card_raw;
    logic             in_session;
    logic             fault_now;
    logic             stop;
    logic             start;
    logic             tmr_done;
    logic [1:0]       div_sel;
    logic             wr_go;
    logic             rd_go;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == ADDR_CTRL) || (a == ADDR_STATUS);
    endfunction

    // Every pin input passes two flip-flops; only the second stage is read.
    // Reset loads the idle pin levels so no false request edge or line fall follows reset.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sync1_q <= SY_IDLE;
            sync2_q <= SY_IDLE;
        end else begin
            sync1_q <= {i_host_line, i_card_line, i_fault, i_card_supply_stable, i_divider_select_lo,
                        i_divider_select_hi, i_card_detect, i_host_reset_request, i_session_request_n};
            sync2_q <= sync1_q;
        end
    end

    assign req_n    = sync2_q[SY_REQ];
    assign host_rst = sync2_q[SY_HRST];
    assign card_raw = sync2_q[SY_DET];
    assign flt      = sync2_q[SY_FLT +: 5];
    assign div_sel  = {sync2_q[SY_DHI], sync2_q[SY_DLO]};

    // Session control terms. Pin current limiting has no input here, so it never reaches the host.
    assign in_session = state_q inside {S_RAMP, S_ACT_IO, S_ACT_CLK, S_ACTIVE};
    assign fault_now  = in_session && ((|flt) || !card_raw);
    assign stop       = in_session && (req_n || fault_now || ctrl_abort_q);
    assign start      = state_q == S_STANDBY && req_prev_q && !req_n && present_q && card_raw
                        && !flt.supply_drop && !ctrl_abort_q;
    assign tmr_done   = tmr_q == '0;

    // Main sequencer. A stop from any session state jumps straight to deactivation.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_q <= S_STANDBY;
            tmr_q   <= '0;
        end else begin
            tmr_q <= tmr_done ? tmr_q : tmr_q - 1'b1;
            case (state_q)
                S_STANDBY: begin
                    if (start) begin
                        state_q <= S_RAMP;
                    end
                end
                S_RAMP: begin
                    if (sync2_q[SY_STABLE]) begin
                        state_q <= S_ACT_IO;
                        tmr_q   <= STEP_LD;
                    end
                end
                S_ACT_IO: begin
                    if (tmr_done) begin
                        state_q <= S_ACT_CLK;
                        tmr_q   <= STEP_LD;
                    end
                end
                S_ACT_CLK: begin
                    if (gated_q) begin
                        tmr_q <= STEP_LD;
                    end else if (tmr_done) begin
                        state_q <= S_ACTIVE;
                    end
                end
                S_ACTIVE: begin
                    state_q <= S_ACTIVE;
                end
                S_DEACT_RST: begin
                    if (tmr_done) begin
                        state_q <= S_DEACT_IO;
                        tmr_q   <= STEP_LD;
                    end
                end
                S_DEACT_IO: begin
                    if (tmr_done) begin
                        state_q <= S_DEACT_VCC;
                        tmr_q   <= STEP_LD;
                    end
                end
                S_DEACT_VCC: begin
                    if (tmr_done) begin
                        state_q <= S_STANDBY;
                    end
                end
                default: state_q <= S_STANDBY;
            endcase
            if (stop) begin
                state_q <= S_DEACT_RST;
                tmr_q   <= GAP_LD;
            end
        end
    end

    // Request edge detect and clock-gated mode capture at session start.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            req_prev_q <= 1'b1;
            gated_q    <= 1'b0;
        end else begin
            req_prev_q <= req_n;
            if (start) begin
                gated_q <= host_rst;
            end else if (!host_rst || state_q == S_STANDBY) begin
                gated_q <= 1'b0;
            end
        end
    end

    // Insertion debounce; removal clears presence at once.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            deb_cnt_q <= '0;
            present_q <= 1'b0;
        end else if (!card_raw) begin
            deb_cnt_q <= '0;
            present_q <= 1'b0;
        end else if (!present_q) begin
            if (deb_cnt_q == DEB_W'(DEBOUNCE_CYCLES - 1)) begin
                present_q <= 1'b1;
            end else begin
                deb_cnt_q <= deb_cnt_q + 1'b1;
            end
        end
    end

    // Fault latch holds the interrupt low until the host has released the request and
    // deactivation is over; the set wins over the clear.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            fault_q      <= 1'b0;
            fault_snap_q <= '0;
        end else if (fault_now) begin
            fault_q      <= 1'b1;
            fault_snap_q <= flt;
        end else if (state_q == S_STANDBY && req_n) begin
            fault_q <= 1'b0;
        end
    end

    // Interrupt: presence in standby, low on supply drop, fault or removal.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            int_q <= 1'b0;
        end else begin
            int_q <= present_q && card_raw && !fault_q && !fault_now && !flt.supply_drop;
        end
    end

    // Card-side enables registered from the state so each step lands on its own edge.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            supply_en_q <= 1'b0;
            io_en_q     <= 1'b0;
            clk_run_q   <= 1'b0;
            rst_q       <= 1'b0;
        end else begin
            supply_en_q <= state_q != S_STANDBY;
            // Deactivation only holds what was already on, so an early stop never wakes a contact.
            io_en_q     <= state_q inside {S_ACT_IO, S_ACT_CLK, S_ACTIVE}
                           || (io_en_q && state_q inside {S_DEACT_RST, S_DEACT_IO});
            clk_run_q   <= (state_q == S_ACT_CLK && !gated_q) || state_q == S_ACTIVE
                           || (clk_run_q && state_q == S_DEACT_RST);
            rst_q       <= state_q == S_ACTIVE && host_rst && !gated_q && !stop;
        end
    end

    // Divider counter restarts from zero so the divided clock always begins low.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            div_cnt_q  <= '0;
            card_clk_q <= 1'b0;
        end else if (!clk_run_q) begin
            div_cnt_q  <= '0;
            card_clk_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
            case (div_sel)
                DIV8:    card_clk_q <= div_cnt_q[2];
                DIV4:    card_clk_q <= div_cnt_q[1];
                DIV2:    card_clk_q <= div_cnt_q[0];
                default: card_clk_q <= 1'b0;
            endcase
        end
    end

    // Undivided mode gates the core clock itself; its first pulse may be shortened.
    assign o_card_clock_out = (div_sel == DIV1) ? (clk_run_q & i_core_clk) : card_clk_q;
    assign o_card_supply_en = supply_en_q;
    assign o_card_reset_out = rst_q;
    assign o_int_n          = int_q;
    assign o_card_line_o    = '0;
    assign o_host_line_o    = '0;

    // Three identical level-shifter channels: data, aux a, aux b.
    for (genvar g = 0; g < 3; g++) begin : g_chan
        ccs_chan u_chan (
            .i_core_clk (i_core_clk),
            .i_rst      (i_rst),
            .i_en       (io_en_q),
            .i_host_lvl (sync2_q[SY_HOST + g]),
            .i_card_lvl (sync2_q[SY_CARD + g]),
            .o_host_oe  (o_host_line_oe[g]),
            .o_card_oe  (o_card_line_oe[g])
        );
    end

    // Register slave. Write address and data are taken together, one at a time.
    assign wr_go     = i_awvalid && i_wvalid && !bvalid_q;
    assign o_awready = wr_go;
    assign o_wready  = wr_go;
    assign rd_go     = i_arvalid && !rvalid_q;
    assign o_arready = !rvalid_q;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            bvalid_q     <= 1'b0;
            bresp_q      <= RESP_OKAY;
            ctrl_abort_q <= CTRL_RST;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= addr_hit(i_awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (i_awaddr == ADDR_CTRL && i_wstrb[0]) begin
                ctrl_abort_q <= i_wdata[CTRL_ABORT];
            end
        end else if (i_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Status word shows live sequencer state.
    always_comb begin
        status_w                   = '0;
        status_w[ST_PRESENT]       = present_q;
        status_w[ST_INT]           = int_q;
        status_w[ST_FAULT]         = fault_q;
        status_w[ST_SESSION]       = in_session;
        status_w[ST_CLK]           = clk_run_q;
        status_w[ST_FSNAP +: 5]    = fault_snap_q;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= addr_hit(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= (i_araddr == ADDR_CTRL) ? {31'h0, ctrl_abort_q}
                      : (i_araddr == ADDR_STATUS) ? status_w : 32'h0;
        end else if (i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign o_bvalid = bvalid_q;
    assign o_bresp  = bresp_q;
    assign o_rvalid = rvalid_q;
    assign o_rresp  = rresp_q;
    assign o_rdata  = rdata_q;

    // Helper: cycles spent with the card reset low and the clock still running.
    always_ff @(posedge i_core_clk) begin
        if (i_rst || state_q != S_DEACT_RST) begin
            gap_q <= '0;
        end else if (clk_run_q) begin
            gap_q <= gap_q + 1'b1;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    AST_RESET_STANDBY: assert property (
        $past(i_rst) |-> state_q == S_STANDBY && !o_card_supply_en) else $error("Not in standby after reset.");
    AST_STANDBY_QUIET: assert property (
        (state_q == S_STANDBY && $past(state_q) == S_STANDBY) |->
        (o_card_line_oe == 3'h7 && o_host_line_oe == 3'h0 && !o_card_reset_out && !clk_run_q))
        else $error("Standby contacts not quiet.");
    AST_PRESENCE_INT: assert property (
        (state_q == S_STANDBY && req_n && present_q && card_raw && !fault_q && !flt.supply_drop) |=> o_int_n)
        else $error("Interrupt low with card present.");
    AST_RAMP_LOW: assert property (
        state_q == S_RAMP |=> (!clk_run_q && !o_card_reset_out && o_card_line_oe == 3'h7))
        else $error("Card signal active during ramp.");
    AST_GATED_CLOCK: assert property (
        (state_q == S_ACT_CLK && gated_q) |=> !clk_run_q) else $error("Clock started while held.");
    AST_DEACT_GAP: assert property (
        $rose(state_q == S_DEACT_IO) |-> gap_q == (clk_run_q ? CNT_W'(DEACT_GAP_CYC) : CNT_W'(0)))
        else $error("Clock stop spacing wrong.");
    AST_SUPPLY_LAST: assert property (
        $fell(o_card_supply_en) |-> (o_card_line_oe == 3'h7 && !clk_run_q && !o_card_reset_out))
        else $error("Supply removed before other contacts.");
    AST_FAULT_SHUTDOWN: assert property (
        fault_now |=> (!o_int_n && state_q == S_DEACT_RST && !o_card_reset_out))
        else $error("Fault did not shut the session.");
    AST_DROP_INT: assert property (
        (!in_session && flt.supply_drop) |=> !o_int_n) else $error("Supply drop not flagged.");
    AST_REMOVAL: assert property (
        $fell(card_raw) |=> ##[0:1] !o_int_n) else $error("Removal not flagged.");
    AST_DEBOUNCE: assert property (
        $rose(present_q) |-> $past(deb_cnt_q) == DEB_W'(DEBOUNCE_CYCLES - 1)) else $error("Debounce too short.");

    COV_ACTIVE: cover property ($rose(state_q == S_ACTIVE));
    COV_FAULT: cover property (fault_now ##1 state_q == S_DEACT_RST);
    COV_GATED: cover property (gated_q ##1 !gated_q && state_q == S_ACT_CLK);

endmodule

/* File: test/ccs_card_model.sv */
`timescale 1ns/1ps
module ccs_card_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_inserted,
    input  wire logic       i_supply_en,
    input  wire logic [2:0] i_dev_oe,
    input  wire logic [2:0] i_card_pull,
    output logic            o_card_detect,
    output logic            o_supply_stable,
    output logic [2:0]      o_line
);
    logic [3:0] ramp_q;
    // The supply needs fifteen cycles to settle, so the ramp step is really seen.
    always_ff @(posedge i_core_clk) begin
        ramp_q <= i_supply_en ? ramp_q + 4'(ramp_q != 4'hf) : 4'h0;
    end
    assign o_card_detect = i_inserted;
    assign o_supply_stable = ramp_q == 4'hf;
    // Pulled-up wires read low whenever either side pulls them.
    assign o_line = ~(i_dev_oe | i_card_pull);
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import ccs_pkg::*;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, rq_n = 1, hr = 0, ins = 0;
    logic        awr, wr, bv, arr, rv, sup, stb, det, rout, cclk, int_n, io_on, io_off;
    logic [7:0]  aw = 0, ar = 0;
    logic [31:0] wd = 0, rd, rdo;
    logic [1:0]  rs, bresp, rresp, dv = 0;
    logic [2:0]  cl, coe, hoe, cp = 0, hp = 0, clo, hlo;
    ccs_fault_t  flt = '0;
    int          failures = 0, compares = 0, cyc = 0, ed = 0, e0;
    ccs_sequencer #(.DEBOUNCE_CYCLES(20)) uut (.i_core_clk(clk), .i_rst(rst), .i_awaddr(aw), .i_awvalid(awv),
        .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr), .o_bresp(bresp), .o_bvalid(bv),
        .i_bready(bre), .i_araddr(ar), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdo), .o_rresp(rresp),
        .o_rvalid(rv), .i_rready(rre), .i_session_request_n(rq_n), .i_host_reset_request(hr), .i_card_detect(det),
        .i_divider_select_hi(dv[1]), .i_divider_select_lo(dv[0]), .i_card_supply_stable(stb), .i_fault(flt),
        .i_card_line(cl), .o_card_line_o(clo), .o_card_line_oe(coe), .i_host_line(~(hoe | hp)), .o_host_line_o(hlo),
        .o_host_line_oe(hoe), .o_card_supply_en(sup), .o_card_reset_out(rout), .o_card_clock_out(cclk),
        .o_int_n(int_n));
    ccs_card_model card (.i_core_clk(clk), .i_inserted(ins), .i_supply_en(sup), .i_dev_oe(coe), .i_card_pull(cp),
        .o_card_detect(det), .o_supply_stable(stb), .o_line(cl));
    // Line-state flags that the wait task can poll.
    always_comb begin
        io_on = coe == 3'h0;
        io_off = coe == 3'h7;
    end
    // Edges are counted on the card clock itself, so the undivided mode is measured too.
    always @(posedge cclk) ed++;
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic till(ref logic s, input logic v, input int k);
        for (int i = 0; i < k && s !== v; i++) @(posedge clk);
    endtask
    // Input clock cycles expected per card clock rise, from the select code.
    function automatic int ratio(input logic [1:0] s);
        case (s)
            DIV8: return 8;
            DIV4: return 4;
            DIV2: return 2;
            default: return 1;
        endcase
    endfunction
    task automatic runs(input logic e);
        e0 = ed;
        repeat (16) @(posedge clk);
        chk("clk_run", 32'(e), 32'(ed != e0));
        if (e)
            chk("clk_edges", 32'(16 / ratio(dv)), 32'(ed - e0));
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awv <= 1;
        wv <= 1;
        aw <= a;
        wd <= d;
        bre <= 1;
        @(posedge clk);
        while (awr !== 1 || wr !== 1) @(posedge clk);
        awv <= 0;
        wv <= 0;
        while (bv !== 1) @(posedge clk);
        bre <= 0;
        chk("bresp", 32'(RESP_OKAY), 32'(bresp));
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a);
        arv <= 1;
        ar <= a;
        rre <= 1;
        @(posedge clk);
        while (arr !== 1) @(posedge clk);
        arv <= 0;
        while (rv !== 1) @(posedge clk);
        rre <= 0;
        rd = rdo;
        rs = rresp;
        @(posedge clk);
    endtask
    task automatic close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // A hang is cut short well beyond the few thousand cycles the run needs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        e0 = $urandom(15);
        repeat (5) @(posedge clk);
        rst <= 0;
        dv <= 2'($urandom);
        repeat (3) @(posedge clk);
        chk("standby", 32'h0, {sup, rout, cclk, int_n, hoe});
        chk("card_oe", 32'h7, 32'(coe));
        chk("line_o", 32'h0, {clo, hlo});
        ins <= 1;
        repeat (12) @(posedge clk);
        chk("int_early", 32'h0, 32'(int_n));
        till(int_n, 1, 40);
        chk("int_present", 32'h1, 32'(int_n));
        flt.supply_drop <= 1;
        repeat (4) @(posedge clk);
        chk("int_drop", 32'h0, 32'(int_n));
        flt.supply_drop <= 0;
        repeat (4) @(posedge clk);
        chk("int_back", 32'h1, 32'(int_n));
        axw(ADDR_CTRL, 32'h0);
        axr(ADDR_STATUS);
        chk("status", 32'h3, rd & 32'h7);
        axr(8'h10);
        chk("rresp", 32'(RESP_SLVERR), 32'(rs));
        hr <= 1;
        rq_n <= 0;
        till(sup, 1, 20);
        chk("ramp", 32'h3c, {sup, coe, rout, cclk});
        till(io_on, 1, 100);
        chk("io_on", 32'h1, 32'(io_on));
        repeat (120) @(posedge clk);
        runs(0);
        hr <= 0;
        repeat (60) @(posedge clk);
        runs(1);
        hr <= 1;
        till(rout, 1, 200);
        chk("card_reset", 32'h1, 32'(rout));
        cp <= 3'h1;
        repeat (50) @(posedge clk);
        hp <= 3'h2;
        repeat (50) @(posedge clk);
        chk("owners", 32'h0a, {hoe, coe});
        cp <= 0;
        hp <= 0;
        repeat (50) @(posedge clk);
        chk("idle", 32'h0, {hoe, coe});
        rq_n <= 1;
        dv <= dv + 2'h1;
        till(rout, 0, 10);
        repeat (550) @(posedge clk);
        runs(1);
        till(io_off, 1, 200);
        chk("deact_io", 32'h2, {sup, cclk});
        runs(0);
        till(sup, 0, 100);
        chk("deact_sup", 32'h0, 32'(sup));
        for (int k = 0; k < 2; k++) begin
            hr <= 0;
            rq_n <= 0;
            repeat (300) @(posedge clk);
            if (k == 0)
                flt <= ccs_fault_t'(5'h1 << ($urandom % 5));
            else
                ins <= 0;
            repeat (4) @(posedge clk);
            chk("int_fault", 32'h0, 32'(int_n));
            till(sup, 0, 900);
            chk("auto_off", 32'h0, 32'(sup));
            rq_n <= 1;
            flt <= '0;
            repeat (10) @(posedge clk);
            chk("int_after", 32'(k == 0), 32'(int_n));
        end
        close_out();
    end
endmodule
